// ### sim/itfd_decoder_asserts.sv
// Purpose: Port checks for the terminal decoder.
// Assumes: One clock domain, synchronous reset.
// Notes: Bound to every decoder instance.
`timescale 1ns/1ns
`include "itfd_params.svh"

module itfd_decoder_asserts (
  input wire logic mclk,
  input wire logic srst,
  input wire logic reg_rd,
  input wire logic [`ITFD_DATA_W-1:0] reg_rdata,
  input wire logic user_fault_a,
  input wire logic user_fault_b,
  input wire logic fault_trip,
  input wire logic [7:0] fault_code,
  input wire logic estop_cmd,
  input wire logic cur_limit_hold,
  input wire logic decel_stop_cmd,
  input wire logic dc_brake_cmd,
  input wire logic [1:0] ramp_group,
  input wire logic runtime_clr,
  input wire logic ups_search,
  input wire logic ups_single_phase
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence s_a_rise;
    $rose(user_fault_a);
  endsequence

  sequence s_rt_pulse;
    runtime_clr ##1 !runtime_clr;
  endsequence

  // ==========================================================
  // Assertions
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == '0) else $error("rdata not idle");
  chk_trip_or: assert property (
    fault_trip == (user_fault_a | user_fault_b)) else $error("trip bad");
  chk_fault_a_code: assert property (
    s_a_rise |-> fault_code == 8'h1B) else $error("fault a code");
  chk_fault_b_code: assert property (
    $rose(user_fault_b) && !$rose(user_fault_a) |-> fault_code == 8'h1C)
    else $error("fault b code");
  chk_fault_hold: assert property (
    !$rose(user_fault_a) && !$rose(user_fault_b) |-> $stable(fault_code))
    else $error("fault code moved");
  chk_estop_hold: assert property (
    estop_cmd == cur_limit_hold) else $error("current hold bad");
  chk_estop_first: assert property (
    estop_cmd |-> !(decel_stop_cmd || dc_brake_cmd))
    else $error("estop not first");
  chk_ext_ramp4: assert property (
    decel_stop_cmd |-> ramp_group == 2'h3) else $error("ramp not four");
  chk_brake_order: assert property (
    dc_brake_cmd |-> !decel_stop_cmd) else $error("brake with decel");
  chk_rt_pulse: assert property (
    runtime_clr |-> s_rt_pulse) else $error("clear pulse long");
  chk_ups_pair: assert property (
    ups_single_phase |-> ups_search) else $error("ups search off");
endmodule // itfd_decoder_asserts

bind itfd_decoder itfd_decoder_asserts itfd_decoder_asserts_i (
  .mclk(mclk), .srst(srst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .user_fault_a(user_fault_a), .user_fault_b(user_fault_b),
  .fault_trip(fault_trip), .fault_code(fault_code),
  .estop_cmd(estop_cmd), .cur_limit_hold(cur_limit_hold),
  .decel_stop_cmd(decel_stop_cmd), .dc_brake_cmd(dc_brake_cmd),
  .ramp_group(ramp_group), .runtime_clr(runtime_clr),
  .ups_search(ups_search), .ups_single_phase(ups_single_phase));

// ### sim/itfd_switches.sv
// Purpose: Contact model driving the terminal pins.
// Assumes: Target levels change only after a rising edge.
// Notes: Each change shows the new level, then its inverse on all pins for one cycle, before settling.
`timescale 1ns/1ns

module itfd_switches (
  input wire logic mclk,
  input wire logic [7:0] level,
  output logic [7:0] pins
);
  // ==========================================================
  // Bouncing contacts
  logic [7:0] settled_r;
  logic [1:0] phase_r;

  initial begin
    pins = 8'h00;
    settled_r = 8'h00;
    phase_r = 2'h0;
  end

  always @(posedge mclk) begin
    if (phase_r == 2'h0 && level !== settled_r) begin
      pins <= level;
      phase_r <= 2'h1;
    end else if (phase_r == 2'h1) begin
      pins <= ~level;
      phase_r <= 2'h2;
    end else if (phase_r == 2'h2) begin
      pins <= level;
      settled_r <= level;
      phase_r <= 2'h0;
    end
  end
endmodule // itfd_switches

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the terminal decoder.
// Assumes: 10 MHz mclk, register port with one-cycle read data.
// Notes: Three code tables, random terminal states per step.
`timescale 1ns/1ns

module tb_top;
  // ==========================================================
  // Signals
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sw_level = 8'h00;
  logic [7:0] term_in;
  logic [15:0] main_src_val = 16'h0000;
  logic [15:0] aux_src_val = 16'h0000;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic [15:0] main_freq_out, aux_freq_out, ref_value, ref_freq;
  logic [1:0] motor_group, ramp_group;
  logic [7:0] fault_code, fcv;
  logic [3:0] ref_index, idx;
  logic pid_set_sel, user_fault_a, user_fault_b, fault_trip, torque_mode;
  logic estop_cmd, cur_limit_hold, decel_stop_cmd, dc_brake_cmd, dcl;
  logic runtime_clr, ups_search, ups_single_phase, irq;
  logic [4:0] rs;
  logic ac [64];
  logic pa [64];
  int mismatches = 0;
  int n_compared = 0;
  int rt_seen = 0;
  int rt_exp = 0;
  logic [31:0] xa;
  int ref_q[$];
  int k, i, t, w, mv, av, maxf, preset, ctrl, mask, stat;
  logic [5:0] cfg [3][8] = '{
    '{6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h29, 6'h2A},
    '{6'h27, 6'h28, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h30},
    '{6'h31, 6'h32, 6'h35, 6'h36, 6'h2F, 6'h30, 6'h2C, 6'h2F}};

  always #50 mclk = ~mclk;

  // Count running time clear pulses
  always @(posedge mclk) begin
    if (runtime_clr === 1'b1) begin
      rt_seen <= rt_seen + 1;
    end
  end

  itfd_switches itfd_switches_i (.mclk(mclk), .level(sw_level),
    .pins(term_in));

  itfd_decoder itfd_decoder_i (.mclk(mclk), .srst(srst),
    .term_in(term_in), .main_src_val(main_src_val),
    .aux_src_val(aux_src_val), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .main_freq_out(main_freq_out),
    .aux_freq_out(aux_freq_out), .motor_group(motor_group),
    .pid_set_sel(pid_set_sel), .user_fault_a(user_fault_a),
    .user_fault_b(user_fault_b), .fault_code(fault_code),
    .fault_trip(fault_trip), .torque_mode(torque_mode),
    .estop_cmd(estop_cmd), .cur_limit_hold(cur_limit_hold),
    .decel_stop_cmd(decel_stop_cmd), .dc_brake_cmd(dc_brake_cmd),
    .runtime_clr(runtime_clr), .ref_index(ref_index),
    .ref_value(ref_value), .ref_freq(ref_freq),
    .ramp_group(ramp_group), .ups_search(ups_search),
    .ups_single_phase(ups_single_phase), .irq(irq));

  // ==========================================================
  // Tasks
  task chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task final_report;
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    #2000000;
    mismatches++;
    final_report;
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(29983));
    t = 0;
    fcv = 8'h00;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rd(8'h28);
    chk("maxfreq_rst", d, 32'h00001388);
    rd(8'h00);
    chk("fcode_rst", d, 32'h00000000);
    rd(8'hFC);
    chk("unmapped", d, 32'h00000000);
    for (k = 0; k < 3; k++) begin
      @(posedge mclk) sw_level <= 8'h00;
      repeat (10) @(posedge mclk);
      t = 0;
      for (i = 0; i < 8; i++) wr(8'(4 * i), 32'(cfg[k][i]));
      maxf = $urandom_range(16'hFFFF, 1);
      preset = $urandom_range(16'hFFFF);
      ctrl = $urandom_range(15);
      mask = $urandom_range(31);
      wr(8'h28, maxf);
      wr(8'h24, preset);
      wr(8'h20, ctrl);
      wr(8'h30, mask);
      wr(8'h2C, 32'h0000001F);
      stat = 0;
      ref_q = {};
      for (i = 0; i < 16; i++) begin
        w = (i == 15) ? 16'h8000 : (i == 14) ? 16'hFFFF :
          $urandom_range(16'hFFFF);
        ref_q.push_back(w);
        wr(8'(8'h40 + 4 * i), w);
      end
      for (i = 0; i < 64; i++) ac[i] = 1'b0;
      repeat (12) begin
        pa = ac;
        t = $urandom_range(255);
        mv = $urandom_range(16'hFFFF);
        av = $urandom_range(16'hFFFF);
        ctrl = $urandom_range(15);
        if (k == 2 && t[0]) ctrl = ctrl | 12;
        wr(8'h20, ctrl);
        @(posedge mclk);
        sw_level <= t[7:0];
        main_src_val <= mv[15:0];
        aux_src_val <= av[15:0];
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        for (i = 0; i < 64; i++) ac[i] = 1'b0;
        for (i = 0; i < 8; i++) ac[cfg[k][i]] = ac[cfg[k][i]] | t[i];
        rs = {ac[6'h32] & !pa[6'h32], ac[6'h30] & !pa[6'h30],
          ac[6'h2F] & !pa[6'h2F], ac[6'h2D] & !pa[6'h2D],
          ac[6'h2C] & !pa[6'h2C]};
        stat = stat | rs;
        if (rs[4] && ctrl[2] && ctrl[3]) rt_exp++;
        if (rs[0]) fcv = 8'h1B;
        else if (rs[1]) fcv = 8'h1C;
        dcl = ac[6'h30] & !ac[6'h2F];
        idx = {ac[6'h0F], ac[6'h0E], ac[6'h0D], ac[6'h0C]};
        w = ref_q[idx] > 16'h8000 ? 16'h8000 : ref_q[idx];
        chk("main", main_freq_out, ac[6'h27] ? preset : mv);
        chk("aux", aux_freq_out, ac[6'h28] ? preset : av);
        chk("motor", motor_group, {ac[6'h2A], ac[6'h29]});
        chk("pid", pid_set_sel, ctrl[0] & ac[6'h2B]);
        chk("fault_a", user_fault_a, ac[6'h2C]);
        chk("fault_b", user_fault_b, ac[6'h2D]);
        chk("fault_code", fault_code, fcv);
        chk("torque", torque_mode, ctrl[1] ^ ac[6'h2E]);
        chk("estop", estop_cmd, ac[6'h2F]);
        chk("decel", decel_stop_cmd, dcl);
        chk("dc", dc_brake_cmd, ac[6'h31] & !ac[6'h30] & !ac[6'h2F]);
        chk("ramp", ramp_group, dcl ? 2'h3 : {ac[6'h11], ac[6'h10]});
        chk("index", ref_index, idx);
        chk("ref_value", ref_value, ref_q[idx]);
        chk("ref_freq", ref_freq, (longint'(w) * maxf) >> 15);
        chk("ups", ups_search, ac[6'h35] | ac[6'h36]);
        chk("ups1", ups_single_phase, ac[6'h36]);
        rd(8'h34);
        chk("term", d, t);
        chk("rtclr", rt_seen, rt_exp);
        xa = 32'({ac[6'h36], ac[6'h35] | ac[6'h36], 1'b0,
          ac[6'h31] & !ac[6'h30] & !ac[6'h2F], dcl, ac[6'h2F],
          ctrl[1] ^ ac[6'h2E], ac[6'h2C] | ac[6'h2D], ctrl[0] & ac[6'h2B],
          ac[6'h2A], ac[6'h29], dcl ? 2'h3 : {ac[6'h11], ac[6'h10]}, idx});
        rd(8'h38);
        chk("action", d, xa);
        rd(8'h2C);
        chk("int_stat", d, stat);
        chk("irq", irq, (stat & mask) != 0);
        w = $urandom_range(31);
        wr(8'h2C, w);
        stat = stat & ~w;
        repeat (2) @(posedge mclk);
        #1 chk("irq_clr", irq, (stat & mask) != 0);
      end
    end
    final_report;
  end
endmodule // tb_top

// ### verilog/itfd_decoder.sv
// Purpose: Decode digital input terminals into drive control actions.
// Assumes: 10 MHz mclk, synchronous active-high srst, pins asynchronous.
// Notes: Read data valid only in the cycle after the read strobe.
//
// Overview of operation
// - Code 39 swaps main source for preset
// - Code 40 swaps auxiliary source for preset
// - Codes 41, 42 form motor selector
// - Code 43 picks second PID set when enabled
// - Codes 44, 45 raise user faults
// - Code 46 selects opposite control mode
// - Code 47 fastest stop at current limit
// - Code 48 decelerating stop using ramp four
// - Code 49 decelerate then DC brake
// - Code 50 clears running time if enabled
// - Four terminals index sixteen references
// - Full-scale reference equals maximum frequency
// - Selected reference feeds PID or V/F
// - Two terminals choose ramp group 1-4
// - Codes 53, 54 enable UPS direction search
// - Motor states 00..11 map groups 1..4
`timescale 1ns/1ns
`include "itfd_params.svh"

module itfd_decoder (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [`ITFD_NUM_TERM-1:0] term_in,
  input wire logic [`ITFD_FREQ_W-1:0] main_src_val,
  input wire logic [`ITFD_FREQ_W-1:0] aux_src_val,
  input wire logic [`ITFD_ADDR_W-1:0] reg_addr,
  input wire logic [`ITFD_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`ITFD_DATA_W-1:0] reg_rdata,
  output logic [`ITFD_FREQ_W-1:0] main_freq_out,
  output logic [`ITFD_FREQ_W-1:0] aux_freq_out,
  output logic [1:0] motor_group,
  output logic pid_set_sel,
  output logic user_fault_a,
  output logic user_fault_b,
  output logic [7:0] fault_code,
  output logic fault_trip,
  output logic torque_mode,
  output logic estop_cmd,
  output logic cur_limit_hold,
  output logic decel_stop_cmd,
  output logic dc_brake_cmd,
  output logic runtime_clr,
  output logic [3:0] ref_index,
  output logic [`ITFD_FREQ_W-1:0] ref_value,
  output logic [`ITFD_FREQ_W-1:0] ref_freq,
  output logic [1:0] ramp_group,
  output logic ups_search,
  output logic ups_single_phase,
  output logic irq
);

  // ==========================================================
  // Function code match over active terminals
  function automatic logic code_on(
    input logic [`ITFD_NUM_TERM-1:0] act,
    input logic [`ITFD_NUM_TERM*`ITFD_FC_W-1:0] fc,
    input logic [`ITFD_FC_W-1:0] code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `ITFD_NUM_TERM; i++) begin
      if (act[i] && fc[i*`ITFD_FC_W +: `ITFD_FC_W] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ==========================================================
  // Storage
  logic [`ITFD_NUM_TERM-1:0] sync1_r;
  logic [`ITFD_NUM_TERM-1:0] sync2_r;
  logic [`ITFD_NUM_TERM-1:0] sync3_r;
  logic [`ITFD_NUM_TERM-1:0] term_r;
  logic [`ITFD_NUM_TERM*`ITFD_FC_W-1:0] fcode_r;
  logic [3:0] ctrl_r;
  logic [`ITFD_FREQ_W-1:0] preset_r;
  logic [`ITFD_FREQ_W-1:0] maxfreq_r;
  logic [`ITFD_FREQ_W-1:0] ref_mem_r [`ITFD_NUM_REF];
  logic [`ITFD_INT_W-1:0] int_stat_r;
  logic [`ITFD_INT_W-1:0] int_mask_r;
  logic [`ITFD_INT_W-1:0] int_stat_nxt;
  logic [`ITFD_INT_W-1:0] evt;
  logic fa_d_r;
  logic fb_d_r;
  logic es_d_r;
  logic xs_d_r;
  logic rt_d_r;
  itfd_pkg::itfd_stop_t stop_nxt;
  logic [`ITFD_FREQ_W-1:0] ref_clip;
  logic [2*`ITFD_FREQ_W-1:0] ref_prod;

  // Decoded levels
  logic f_ref0, f_ref1, f_ref2, f_ref3;
  logic f_ramp0, f_ramp1;
  logic f_main, f_aux, f_mot0, f_mot1, f_pid;
  logic f_fa, f_fb, f_swap, f_es, f_xs, f_dc;
  logic f_rt, f_ups, f_ups1;

  // ==========================================================
  // Input synchronisers and agreement filter
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= term_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `ITFD_NUM_TERM; g++) begin : g_filt
      always_ff @(posedge mclk) begin
        if (srst) begin
          term_r[g] <= 1'b0;
        end else if (sync2_r[g] == sync3_r[g]) begin
          term_r[g] <= sync3_r[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Function decode
  always_comb begin
    f_ref0 = code_on(term_r, fcode_r, `ITFD_FC_REF_B0);
    f_ref1 = code_on(term_r, fcode_r, `ITFD_FC_REF_B1);
    f_ref2 = code_on(term_r, fcode_r, `ITFD_FC_REF_B2);
    f_ref3 = code_on(term_r, fcode_r, `ITFD_FC_REF_B3);
    f_ramp0 = code_on(term_r, fcode_r, `ITFD_FC_RAMP_B0);
    f_ramp1 = code_on(term_r, fcode_r, `ITFD_FC_RAMP_B1);
    f_main = code_on(term_r, fcode_r, `ITFD_FC_MAIN_PRESET);
    f_aux = code_on(term_r, fcode_r, `ITFD_FC_AUX_PRESET);
    f_mot0 = code_on(term_r, fcode_r, `ITFD_FC_MOTOR_B0);
    f_mot1 = code_on(term_r, fcode_r, `ITFD_FC_MOTOR_B1);
    f_pid = code_on(term_r, fcode_r, `ITFD_FC_PID_SET);
    f_fa = code_on(term_r, fcode_r, `ITFD_FC_UFAULT_A);
    f_fb = code_on(term_r, fcode_r, `ITFD_FC_UFAULT_B);
    f_swap = code_on(term_r, fcode_r, `ITFD_FC_MODE_SWAP);
    f_es = code_on(term_r, fcode_r, `ITFD_FC_ESTOP);
    f_xs = code_on(term_r, fcode_r, `ITFD_FC_EXT_STOP);
    f_dc = code_on(term_r, fcode_r, `ITFD_FC_DEC_DCBRK);
    f_rt = code_on(term_r, fcode_r, `ITFD_FC_RT_CLR);
    f_ups = code_on(term_r, fcode_r, `ITFD_FC_UPS_EN);
    f_ups1 = code_on(term_r, fcode_r, `ITFD_FC_UPS_1PH);
  end

  // ==========================================================
  // Frequency source overrides
  always_ff @(posedge mclk) begin
    if (srst) begin
      main_freq_out <= `ITFD_RST_FREQ;
      aux_freq_out <= `ITFD_RST_FREQ;
    end else begin
      main_freq_out <= f_main ? preset_r : main_src_val;
      aux_freq_out <= f_aux ? preset_r : aux_src_val;
    end
  end

  // ==========================================================
  // Motor, PID and control mode selection
  always_ff @(posedge mclk) begin
    if (srst) begin
      motor_group <= 2'h0;
      pid_set_sel <= 1'b0;
      torque_mode <= 1'b0;
    end else begin
      motor_group <= {f_mot1, f_mot0};
      pid_set_sel <= ctrl_r[`ITFD_CTRL_PID_TERM] & f_pid;
      torque_mode <= ctrl_r[`ITFD_CTRL_BASE_TORQUE] ^ f_swap;
    end
  end

  // ==========================================================
  // User faults
  always_ff @(posedge mclk) begin
    if (srst) begin
      user_fault_a <= 1'b0;
      user_fault_b <= 1'b0;
      fault_trip <= 1'b0;
      fault_code <= 8'h00;
    end else begin
      user_fault_a <= f_fa;
      user_fault_b <= f_fb;
      fault_trip <= f_fa | f_fb;
      if (f_fa && !fa_d_r) begin
        fault_code <= `ITFD_USER_FAULT_A_CODE;
      end else if (f_fb && !fb_d_r) begin
        fault_code <= `ITFD_USER_FAULT_B_CODE;
      end
    end
  end

  // ==========================================================
  // Stop arbitration
  always_comb begin
    if (f_es) begin
      stop_nxt = itfd_pkg::STOP_EMERGENCY;
    end else if (f_xs) begin
      stop_nxt = itfd_pkg::STOP_DECEL;
    end else if (f_dc) begin
      stop_nxt = itfd_pkg::STOP_DC_BRAKE;
    end else begin
      stop_nxt = itfd_pkg::STOP_NONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      estop_cmd <= 1'b0;
      cur_limit_hold <= 1'b0;
      decel_stop_cmd <= 1'b0;
      dc_brake_cmd <= 1'b0;
    end else begin
      estop_cmd <= 1'b0;
      cur_limit_hold <= 1'b0;
      decel_stop_cmd <= 1'b0;
      dc_brake_cmd <= 1'b0;
      case (stop_nxt)
        itfd_pkg::STOP_EMERGENCY: begin
          estop_cmd <= 1'b1;
          cur_limit_hold <= 1'b1;
        end
        itfd_pkg::STOP_DECEL: begin
          decel_stop_cmd <= 1'b1;
        end
        itfd_pkg::STOP_DC_BRAKE: begin
          dc_brake_cmd <= 1'b1;
        end
        default: begin
          estop_cmd <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Ramp group selection
  always_ff @(posedge mclk) begin
    if (srst) begin
      ramp_group <= 2'h0;
    end else if (stop_nxt == itfd_pkg::STOP_DECEL) begin
      ramp_group <= `ITFD_RAMP_GROUP4;
    end else begin
      ramp_group <= {f_ramp1, f_ramp0};
    end
  end

  // ==========================================================
  // Running time clear and UPS
  always_ff @(posedge mclk) begin
    if (srst) begin
      runtime_clr <= 1'b0;
      ups_search <= 1'b0;
      ups_single_phase <= 1'b0;
    end else begin
      runtime_clr <= f_rt && !rt_d_r && ctrl_r[`ITFD_CTRL_RT_EN_A]
                     && ctrl_r[`ITFD_CTRL_RT_EN_B];
      ups_search <= f_ups | f_ups1;
      ups_single_phase <= f_ups1;
    end
  end

  // ==========================================================
  // Multi-reference selection and scaling
  always_comb begin
    if (ref_value > `ITFD_REF_FULL) begin
      ref_clip = `ITFD_REF_FULL;
    end else begin
      ref_clip = ref_value;
    end
    ref_prod = ref_clip * maxfreq_r;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_index <= 4'h0;
      ref_value <= `ITFD_RST_FREQ;
      ref_freq <= `ITFD_RST_FREQ;
    end else begin
      ref_index <= {f_ref3, f_ref2, f_ref1, f_ref0};
      ref_value <= ref_mem_r[ref_index];
      ref_freq <= ref_prod[`ITFD_REF_FS_SHIFT +: `ITFD_FREQ_W];
    end
  end

  // ==========================================================
  // Edge history
  always_ff @(posedge mclk) begin
    if (srst) begin
      fa_d_r <= 1'b0;
      fb_d_r <= 1'b0;
      es_d_r <= 1'b0;
      xs_d_r <= 1'b0;
      rt_d_r <= 1'b0;
    end else begin
      fa_d_r <= f_fa;
      fb_d_r <= f_fb;
      es_d_r <= f_es;
      xs_d_r <= f_xs;
      rt_d_r <= f_rt;
    end
  end

  // ==========================================================
  // Interrupts
  always_comb begin
    evt = '0;
    evt[`ITFD_INT_UFAULT_A] = f_fa & ~fa_d_r;
    evt[`ITFD_INT_UFAULT_B] = f_fb & ~fb_d_r;
    evt[`ITFD_INT_ESTOP] = f_es & ~es_d_r;
    evt[`ITFD_INT_EXT_STOP] = f_xs & ~xs_d_r;
    evt[`ITFD_INT_RT_CLR] = f_rt & ~rt_d_r;
    int_stat_nxt = int_stat_r;
    if (reg_wr && reg_addr == `ITFD_OFS_INT_STAT) begin
      int_stat_nxt = int_stat_nxt & ~reg_wdata[`ITFD_INT_W-1:0];
    end
    int_stat_nxt = int_stat_nxt | evt;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      int_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      irq <= |(int_stat_nxt & int_mask_r);
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      fcode_r <= {`ITFD_NUM_TERM{`ITFD_RST_FCODE}};
      ctrl_r <= `ITFD_RST_CTRL;
      preset_r <= `ITFD_RST_FREQ;
      maxfreq_r <= `ITFD_RST_MAXFREQ;
      int_mask_r <= '0;
    end else if (reg_wr) begin
      for (int i = 0; i < `ITFD_NUM_TERM; i++) begin
        if (reg_addr == `ITFD_OFS_FCODE + 8'(4 * i)) begin
          fcode_r[i*`ITFD_FC_W +: `ITFD_FC_W] <=
            reg_wdata[`ITFD_FC_W-1:0];
        end
      end
      case (reg_addr)
        `ITFD_OFS_CTRL: ctrl_r <= reg_wdata[3:0];
        `ITFD_OFS_PRESET: preset_r <= reg_wdata[`ITFD_FREQ_W-1:0];
        `ITFD_OFS_MAXFREQ: maxfreq_r <= reg_wdata[`ITFD_FREQ_W-1:0];
        `ITFD_OFS_INT_MASK: int_mask_r <= reg_wdata[`ITFD_INT_W-1:0];
        default: ;
      endcase
    end
  end

  generate
    for (g = 0; g < `ITFD_NUM_REF; g++) begin : g_ref
      always_ff @(posedge mclk) begin
        if (srst) begin
          ref_mem_r[g] <= `ITFD_RST_FREQ;
        end else if (reg_wr && reg_addr == `ITFD_OFS_REF + 8'(4 * g)) begin
          ref_mem_r[g] <= reg_wdata[`ITFD_FREQ_W-1:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Register reads
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        for (int i = 0; i < `ITFD_NUM_TERM; i++) begin
          if (reg_addr == `ITFD_OFS_FCODE + 8'(4 * i)) begin
            reg_rdata <= 32'(fcode_r[i*`ITFD_FC_W +: `ITFD_FC_W]);
          end
        end
        for (int i = 0; i < `ITFD_NUM_REF; i++) begin
          if (reg_addr == `ITFD_OFS_REF + 8'(4 * i)) begin
            reg_rdata <= 32'(ref_mem_r[i]);
          end
        end
        case (reg_addr)
          `ITFD_OFS_CTRL: reg_rdata <= 32'(ctrl_r);
          `ITFD_OFS_PRESET: reg_rdata <= 32'(preset_r);
          `ITFD_OFS_MAXFREQ: reg_rdata <= 32'(maxfreq_r);
          `ITFD_OFS_INT_STAT: reg_rdata <= 32'(int_stat_r);
          `ITFD_OFS_INT_MASK: reg_rdata <= 32'(int_mask_r);
          `ITFD_OFS_TERM: reg_rdata <= 32'(term_r);
          `ITFD_OFS_ACTION: reg_rdata <= 32'({ups_single_phase,
            ups_search, runtime_clr, dc_brake_cmd, decel_stop_cmd,
            estop_cmd, torque_mode, fault_trip, pid_set_sel,
            motor_group, ramp_group, ref_index});
          default: ;
        endcase
      end
    end
  end

endmodule // itfd_decoder

// ### verilog/itfd_params.svh
// Purpose: Offsets, field positions, codes and reset values for itfd.
// Assumes: Word-aligned registers on an 8-bit byte address.
// Notes: Definitions only.
`ifndef ITFD_PARAMS_SVH
`define ITFD_PARAMS_SVH

// ==========================================================
// Sizes
`define ITFD_NUM_TERM 8
`define ITFD_FC_W 6
`define ITFD_FREQ_W 16
`define ITFD_NUM_REF 16
`define ITFD_ADDR_W 8
`define ITFD_DATA_W 32

// ==========================================================
// Terminal function codes
`define ITFD_FC_REF_B0 6'h0C
`define ITFD_FC_REF_B1 6'h0D
`define ITFD_FC_REF_B2 6'h0E
`define ITFD_FC_REF_B3 6'h0F
`define ITFD_FC_RAMP_B0 6'h10
`define ITFD_FC_RAMP_B1 6'h11
`define ITFD_FC_MAIN_PRESET 6'h27
`define ITFD_FC_AUX_PRESET 6'h28
`define ITFD_FC_MOTOR_B0 6'h29
`define ITFD_FC_MOTOR_B1 6'h2A
`define ITFD_FC_PID_SET 6'h2B
`define ITFD_FC_UFAULT_A 6'h2C
`define ITFD_FC_UFAULT_B 6'h2D
`define ITFD_FC_MODE_SWAP 6'h2E
`define ITFD_FC_ESTOP 6'h2F
`define ITFD_FC_EXT_STOP 6'h30
`define ITFD_FC_DEC_DCBRK 6'h31
`define ITFD_FC_RT_CLR 6'h32
`define ITFD_FC_UPS_EN 6'h35
`define ITFD_FC_UPS_1PH 6'h36

// ==========================================================
// Fault codes and ramp groups
`define ITFD_USER_FAULT_A_CODE 8'h1B
`define ITFD_USER_FAULT_B_CODE 8'h1C
`define ITFD_RAMP_GROUP4 2'h3
`define ITFD_REF_FS_SHIFT 15
`define ITFD_REF_FULL 16'h8000

// ==========================================================
// Register byte offsets
`define ITFD_OFS_FCODE 8'h00
`define ITFD_OFS_CTRL 8'h20
`define ITFD_OFS_PRESET 8'h24
`define ITFD_OFS_MAXFREQ 8'h28
`define ITFD_OFS_INT_STAT 8'h2C
`define ITFD_OFS_INT_MASK 8'h30
`define ITFD_OFS_TERM 8'h34
`define ITFD_OFS_ACTION 8'h38
`define ITFD_OFS_REF 8'h40

// ==========================================================
// Control register fields
`define ITFD_CTRL_PID_TERM 0
`define ITFD_CTRL_BASE_TORQUE 1
`define ITFD_CTRL_RT_EN_A 2
`define ITFD_CTRL_RT_EN_B 3

// ==========================================================
// Interrupt status bits
`define ITFD_INT_W 5
`define ITFD_INT_UFAULT_A 0
`define ITFD_INT_UFAULT_B 1
`define ITFD_INT_ESTOP 2
`define ITFD_INT_EXT_STOP 3
`define ITFD_INT_RT_CLR 4

// ==========================================================
// Reset values
`define ITFD_RST_FCODE 6'h00
`define ITFD_RST_CTRL 4'h0
`define ITFD_RST_FREQ 16'h0000
`define ITFD_RST_MAXFREQ 16'h1388

`endif

// ### verilog/itfd_pkg.sv
// Purpose: Types shared by the terminal function decoder.
// Assumes: Constants live in itfd_params.svh.
// Notes: Nothing here is imported.
package itfd_pkg;

  // ==========================================================
  // Stop request arbitration result
  typedef enum logic [1:0] {
    STOP_NONE,
    STOP_DC_BRAKE,
    STOP_DECEL,
    STOP_EMERGENCY
  } itfd_stop_t;

endpackage
